// ---- rtl/pbws_hold_timer.sv ----
// Power switch hold timer that classifies each press.
`timescale 1ns/1ps
`default_nettype none
module pbws_hold_timer
  import pbws_pkg::*;
#(
  parameter int unsigned SHORT_CYC = SHORT_HOLD_CYC,
  parameter int unsigned FORCE_CYC = FORCE_HOLD_CYC
) (
  input wire logic clk,           // Standby clock.
  input wire logic srst,          // Synchronous reset, active high.
  input wire logic button,        // Switch pressed, active high.
  output pbws_hold_t verdict,     // Classification of the last judged hold, kept until the next.
  output logic verdict_vld        // Classification valid pulse.
);

  logic [HOLD_W-1:0] cnt_ff;
  logic btn_ff;
  logic forced_ff;
  pbws_hold_t verdict_ff;
  logic vld_ff;

  assign verdict = verdict_ff;
  assign verdict_vld = vld_ff;

  // The counter saturates so a very long hold cannot wrap into a short one.
  always_ff @(posedge clk) begin
    if (srst) begin
      cnt_ff <= '0;
    end else if (!button) begin
      cnt_ff <= '0;
    end else if (cnt_ff != HOLD_W'(FORCE_CYC)) begin
      cnt_ff <= cnt_ff + HOLD_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      btn_ff <= 1'b0;
    end else begin
      btn_ff <= button;
    end
  end

  // A hold is judged once: at the six-second crossing or at release.
  always_ff @(posedge clk) begin
    if (srst) begin
      forced_ff <= 1'b0;
      verdict_ff <= PBWS_HOLD_NONE;
      vld_ff <= 1'b0;
    end else begin
      vld_ff <= 1'b0;
      if (button && !forced_ff && cnt_ff == HOLD_W'(FORCE_CYC - 1)) begin
        forced_ff <= 1'b1;
        verdict_ff <= PBWS_HOLD_FORCE;
        vld_ff <= 1'b1;
      end else if (!button && btn_ff) begin
        forced_ff <= 1'b0;
        if (!forced_ff) begin
          vld_ff <= 1'b1;
          verdict_ff <= (cnt_ff < HOLD_W'(SHORT_CYC)) ? PBWS_HOLD_SHORT : PBWS_HOLD_NONE;
        end
      end
    end
  end

endmodule
`default_nettype wire

// ---- rtl/pbws_pkg.sv ----
// Shared constants and types of the power button and wake sequencer.
package pbws_pkg;

  localparam int unsigned CLK_HZ = 20_000_000;
  localparam int unsigned SHORT_HOLD_S = 4;
  localparam int unsigned FORCE_HOLD_S = 6;
  localparam int unsigned SHORT_HOLD_CYC = SHORT_HOLD_S * CLK_HZ;
  localparam int unsigned FORCE_HOLD_CYC = FORCE_HOLD_S * CLK_HZ;
  localparam int unsigned HOLD_W = 28;
  localparam int unsigned AC_GUARD_CYC = 20_000_000;

  // Last-power-state policy encodings.
  localparam logic [1:0] LPS_OFF = 2'h0;
  localparam logic [1:0] LPS_ON = 2'h1;
  localparam logic [1:0] LPS_LAST = 2'h2;

  typedef enum logic [2:0] {
    PBWS_S0,
    PBWS_S3,
    PBWS_S4,
    PBWS_S5
  } pbws_state_t;

  // Wake indications delivered by other blocks.
  typedef struct packed {
    logic rtc_alarm;
    logic network_packet_wake;
    logic usb;
    logic pcie_wake;
    logic infrared_remote_wake;
    logic radio;
  } pbws_wake_t;

  // Firmware configuration options.
  typedef struct packed {
    logic usb_s45_en;
    logic deep_sleep;
    logic [1:0] last_state_policy;
    logic sleep_to_s4;
    logic sleep_to_off;
  } pbws_cfg_t;

  typedef enum logic [1:0] {
    PBWS_HOLD_NONE,
    PBWS_HOLD_SHORT,
    PBWS_HOLD_FORCE
  } pbws_hold_t;

endpackage

// ---- rtl/pbws_top.sv ----
// Power-state sequencer driven by the power switch and wake sources.
//
// Overview of operation
// - Short press from soft-off powers on.
// - Short press while working requests configured sleep.
// - Hold over six seconds forces soft-off.
// - Short press while sleeping wakes system.
// - Switch, alarm, network, USB, PCIe, infrared wake.
// - Radio wake indication is always ignored.
// - USB wake from S4/S5 needs option.
// - Alarm/network/PCIe wake from S3 keeps monitor asleep.
// - USB/infrared S4/S5 wake needs deep sleep off.
// - Network S5 wake after G3 needs deep sleep off.
// - No USB/infrared wake right after mains return.
// - Mains return applies stored last-state policy.
// - Context kept in RAM, disk, or none.
`timescale 1ns/1ps
`default_nettype none
module pbws_top
  import pbws_pkg::*;
#(
  parameter int unsigned SHORT_CYC = SHORT_HOLD_CYC,
  parameter int unsigned FORCE_CYC = FORCE_HOLD_CYC,
  parameter int unsigned GUARD_CYC = AC_GUARD_CYC
) (
  input wire logic CORE_CLK,         // Standby clock, 20 MHz.
  input wire logic SRST,             // Standby reset, active high.
  input wire logic PWR_BUTTON,       // Power switch pressed, active high.
  input wire pbws_wake_t WAKE_IN,    // Wake indications, active high levels.
  input wire pbws_cfg_t CFG,         // Firmware options, static levels.
  input wire logic AC_RESTORED,      // Pulse: mains returned after G3.
  input wire logic OS_SLEEP_REQ,     // Pulse: software entering sleep target.
  output pbws_state_t SYS_STATE,     // Current system state.
  output logic MAIN_PWR_EN,          // Main rails on.
  output logic CTX_RAM,              // Context held in memory.
  output logic CTX_DISK,             // Context held on disk.
  output logic COLD_BOOT,            // Next wake needs cold boot.
  output logic SLEEP_REQ,            // Pulse: request sleep from software.
  output logic MONITOR_SLEEP,        // Keep display asleep after wake.
  output logic WAKE_LOGIC_ON         // Wake logic powered.
);

  pbws_state_t state_ff;
  pbws_state_t nxt_state;
  pbws_state_t last_state_ff;
  pbws_hold_t verdict;
  logic verdict_vld;
  logic sleep_req_ff;
  logic monitor_sleep_ff;
  logic g3_ff;
  logic [HOLD_W-1:0] guard_ff;
  logic guard_on;
  logic wake_any;
  logic wake_quiet;
  logic short_hit;
  logic force_hit;

  ////////////////////////////////////////////////////////////////////////////
  // Switch hold timing.

  pbws_hold_timer #(
    .SHORT_CYC(SHORT_CYC),
    .FORCE_CYC(FORCE_CYC)
  ) u_hold (
    .clk(CORE_CLK),
    .srst(SRST),
    .button(PWR_BUTTON),
    .verdict(verdict),
    .verdict_vld(verdict_vld)
  );

  // A verdict only counts in the cycle that its valid pulse stands.
  function automatic logic hold_is(input logic vld, input pbws_hold_t v,
                                   input pbws_hold_t kind);
    hold_is = vld && (v == kind);
  endfunction

  assign short_hit = hold_is(verdict_vld, verdict, PBWS_HOLD_SHORT);
  assign force_hit = hold_is(verdict_vld, verdict, PBWS_HOLD_FORCE);

  ////////////////////////////////////////////////////////////////////////////
  // Mains-loss tracking.

  // Guard window after mains returns; sources that need re-enumeration stay deaf.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      guard_ff <= '0;
    end else if (AC_RESTORED) begin
      guard_ff <= HOLD_W'(GUARD_CYC);
    end else if (guard_ff != '0) begin
      guard_ff <= guard_ff - HOLD_W'(1);
    end
  end
  assign guard_on = (guard_ff != '0);

  // Remembers that soft-off was reached through a full mains loss.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      g3_ff <= 1'b0;
    end else if (AC_RESTORED) begin
      g3_ff <= 1'b1;
    end else if (state_ff == PBWS_S0) begin
      g3_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Wake qualification.

  function automatic logic wake_ok(input pbws_state_t st, input pbws_wake_t w,
                                   input pbws_cfg_t c, input logic guard, input logic g3);
    logic deep;
    logic usb_ok;
    logic ir_ok;
    logic net_ok;
    deep = (st == PBWS_S4 || st == PBWS_S5);
    usb_ok = w.usb && !guard && (!deep || (c.usb_s45_en && !c.deep_sleep));
    ir_ok = w.infrared_remote_wake && !guard && (!deep || !c.deep_sleep);
    net_ok = w.network_packet_wake && !(st == PBWS_S5 && g3 && c.deep_sleep);
    // The radio bit is never looked at.
    wake_ok = w.rtc_alarm || net_ok || w.pcie_wake || usb_ok || ir_ok;
  endfunction

  assign wake_any = (state_ff != PBWS_S0) && wake_ok(state_ff, WAKE_IN, CFG, guard_on, g3_ff);
  assign wake_quiet = WAKE_IN.rtc_alarm || WAKE_IN.network_packet_wake || WAKE_IN.pcie_wake;

  ////////////////////////////////////////////////////////////////////////////
  // State machine.

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      PBWS_S0: begin
        if (force_hit) begin
          nxt_state = PBWS_S5;
        end else if (OS_SLEEP_REQ) begin
          if (CFG.sleep_to_off) begin
            nxt_state = PBWS_S5;
          end else if (CFG.sleep_to_s4) begin
            nxt_state = PBWS_S4;
          end else begin
            nxt_state = PBWS_S3;
          end
        end
      end
      PBWS_S3, PBWS_S4: begin
        if (force_hit) begin
          nxt_state = PBWS_S5;
        end else if (short_hit || wake_any) begin
          nxt_state = PBWS_S0;
        end
      end
      PBWS_S5: begin
        if (short_hit || wake_any) begin
          nxt_state = PBWS_S0;
        end
      end
      default: nxt_state = PBWS_S5;
    endcase
    // Mains return overrides everything else.
    if (AC_RESTORED) begin
      if (CFG.last_state_policy == LPS_ON) begin
        nxt_state = PBWS_S0;
      end else if (CFG.last_state_policy == LPS_LAST && last_state_ff == PBWS_S0) begin
        nxt_state = PBWS_S0;
      end else begin
        nxt_state = PBWS_S5;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      state_ff <= PBWS_S5;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Last state is frozen during the cycle that mains returns.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      last_state_ff <= PBWS_S5;
    end else if (!AC_RESTORED) begin
      last_state_ff <= state_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Requests and display control.

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      sleep_req_ff <= 1'b0;
    end else begin
      sleep_req_ff <= (state_ff == PBWS_S0) && short_hit;
    end
  end

  // Held in S0 until the next judged press so software can decide when to light the display.
  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      monitor_sleep_ff <= 1'b0;
    end else if (state_ff == PBWS_S3 && nxt_state == PBWS_S0) begin
      monitor_sleep_ff <= !short_hit && wake_quiet;
    end else if (state_ff != PBWS_S0 || verdict_vld) begin
      monitor_sleep_ff <= 1'b0;
    end
  end

  assign SYS_STATE = state_ff;
  assign MAIN_PWR_EN = (state_ff == PBWS_S0);
  assign CTX_RAM = (state_ff == PBWS_S3);
  assign CTX_DISK = (state_ff == PBWS_S4);
  assign COLD_BOOT = (state_ff == PBWS_S5);
  // The wake logic sits in the standby domain, so it is never switched off.
  assign WAKE_LOGIC_ON = 1'b1;
  assign SLEEP_REQ = sleep_req_ff;
  assign MONITOR_SLEEP = monitor_sleep_ff;

endmodule
`default_nettype wire

// ---- tb/pbws_checker.sv ----
// Port checker for the power switch and wake sequencer.
`timescale 1ns/1ps
`default_nettype none
module pbws_checker
  import pbws_pkg::*;
#(
  parameter int unsigned SHORT_CYC = 40,
  parameter int unsigned FORCE_CYC = 60,
  parameter int unsigned GUARD_CYC = 20
) (
  input wire logic CORE_CLK, // Clock.
  input wire logic SRST, // Reset.
  input wire logic PWR_BUTTON, // Switch.
  input wire pbws_wake_t WAKE_IN, // Wakes.
  input wire pbws_cfg_t CFG, // Options.
  input wire logic AC_RESTORED, // Mains.
  input wire logic OS_SLEEP_REQ, // Sleep.
  input wire pbws_state_t SYS_STATE, // State.
  input wire logic MAIN_PWR_EN, // Rails.
  input wire logic CTX_RAM, // Memory.
  input wire logic CTX_DISK, // Disk.
  input wire logic COLD_BOOT, // Cold.
  input wire logic SLEEP_REQ, // Request.
  input wire logic MONITOR_SLEEP, // Monitor.
  input wire logic WAKE_LOGIC_ON // Wake logic.
);
  int press_ff;
  int low_ff;
  int unsigned ac_age_ff;
  logic quiet;
  always_ff @(posedge CORE_CLK) press_ff <= (SRST || !PWR_BUTTON) ? 0 : press_ff + 1;
  always_ff @(posedge CORE_CLK) low_ff <= (SRST || PWR_BUTTON) ? 0 : low_ff + 1;
  // A verdict lands two cycles after release, so idle spans of three cycles or fewer are excluded.
  assign quiet = low_ff > 3 && !AC_RESTORED && !OS_SLEEP_REQ;
  // Cycles since mains returned; saturates just past the guard window.
  always_ff @(posedge CORE_CLK) ac_age_ff <= SRST ? GUARD_CYC + 1 : AC_RESTORED ? 1 :
    (ac_age_ff > GUARD_CYC) ? ac_age_ff : ac_age_ff + 1;
  ////////////////////////////////////////////////////////////////
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (SRST);
  sequence short_rel;
    !PWR_BUTTON && press_ff > 0 && press_ff < SHORT_CYC && !AC_RESTORED;
  endsequence
  sequence mid_rel;
    !PWR_BUTTON && press_ff >= SHORT_CYC && press_ff < FORCE_CYC;
  endsequence
  a_short_wakes: assert property (short_rel ##0 SYS_STATE != PBWS_S0
    |-> ##[1:3] SYS_STATE == PBWS_S0) else $error("short press missed working");
  a_short_sleeps: assert property (short_rel ##0 SYS_STATE == PBWS_S0
    |-> ##[1:3] SLEEP_REQ) else $error("short press missed sleep request");
  a_sleep_target: assert property (OS_SLEEP_REQ && SYS_STATE == PBWS_S0 && low_ff > 3
    |-> ##[1:2] SYS_STATE == (CFG.sleep_to_off ? PBWS_S5 : CFG.sleep_to_s4 ? PBWS_S4 : PBWS_S3))
    else $error("wrong sleep target");
  a_force_off: assert property (press_ff == FORCE_CYC |-> ##[0:4] SYS_STATE == PBWS_S5)
    else $error("long hold missed soft off");
  a_mid_idle: assert property (mid_rel |-> ##1 ($stable(SYS_STATE) && !SLEEP_REQ)[*3])
    else $error("middle hold acted");
  a_radio_dead: assert property (SYS_STATE != PBWS_S0 && WAKE_IN == 6'h01 && quiet
    |=> $stable(SYS_STATE)) else $error("radio woke system");
  a_usb_gate: assert property (SYS_STATE inside {PBWS_S4, PBWS_S5} && WAKE_IN == 6'h08
    && (!CFG.usb_s45_en || CFG.deep_sleep) && quiet |=> $stable(SYS_STATE))
    else $error("gated usb woke system");
  a_ctx_decode: assert property (CTX_RAM == (SYS_STATE == PBWS_S3) && WAKE_LOGIC_ON
    && CTX_DISK == (SYS_STATE == PBWS_S4) && COLD_BOOT == (SYS_STATE == PBWS_S5)
    && MAIN_PWR_EN == (SYS_STATE == PBWS_S0)) else $error("state outputs wrong");
  a_guard_deaf: assert property (SYS_STATE != PBWS_S0 && WAKE_IN inside {6'h08, 6'h02}
    && ac_age_ff >= 1 && ac_age_ff <= GUARD_CYC && quiet |=> $stable(SYS_STATE))
    else $error("usb or infrared woke inside mains guard");
  a_monitor_from_s3: assert property ($rose(MONITOR_SLEEP)
    |-> $past(SYS_STATE) == PBWS_S3) else $error("monitor kept asleep outside s3 wake");
endmodule
bind pbws_top pbws_checker #(.SHORT_CYC(SHORT_CYC), .FORCE_CYC(FORCE_CYC),
  .GUARD_CYC(GUARD_CYC)) u_chk (.CORE_CLK(CORE_CLK), .SRST(SRST), .PWR_BUTTON(PWR_BUTTON),
  .WAKE_IN(WAKE_IN), .CFG(CFG), .AC_RESTORED(AC_RESTORED), .OS_SLEEP_REQ(OS_SLEEP_REQ),
  .SYS_STATE(SYS_STATE), .MAIN_PWR_EN(MAIN_PWR_EN), .CTX_RAM(CTX_RAM), .CTX_DISK(CTX_DISK),
  .COLD_BOOT(COLD_BOOT), .SLEEP_REQ(SLEEP_REQ), .MONITOR_SLEEP(MONITOR_SLEEP),
  .WAKE_LOGIC_ON(WAKE_LOGIC_ON));
`default_nettype wire

// ---- tb/pbws_partner.sv ----
// Model of the power switch and the board wake sources.
`timescale 1ns/1ps
`default_nettype none
module pbws_partner
  import pbws_pkg::*;
(
  input wire logic clk, // Standby clock.
  output logic button, // Switch level.
  output pbws_wake_t wake // Wake levels.
);
  // Released wake lines read inactive, so no stale level lingers.
  initial begin
    button = 1'b0;
    wake = '0;
  end
  ////////////////////////////////////////////////////////////////
  task automatic press(input int n);
    @(posedge clk) #1 button = 1'b1;
    repeat (n) @(posedge clk);
    #1 button = 1'b0;
  endtask
  task automatic wake_for(input pbws_wake_t w, input int n);
    @(posedge clk) #1 wake = w;
    repeat (n) @(posedge clk);
    #1 wake = '0;
  endtask
endmodule
`default_nettype wire

// ---- tb/pbws_top_test.sv ----
// Self-checking bench of the power switch and wake sequencer.
`timescale 1ns/1ps
`default_nettype none
module pbws_top_test
  import pbws_pkg::*;
;
  logic clk, srst, ac, osr, btn, sreq, mon;
  logic pwr, cram, cdisk, cboot, wlon;
  logic [3:0] want;
  pbws_cfg_t cfg;
  pbws_wake_t wake;
  pbws_state_t st, last_st;
  logic [3:0] exp_q[$];
  logic [31:0] seed = 32'h0000_004D;
  int bad_count, samples_checked;
  // Fields: usb option, deep sleep, wake expected, wake lines.
  logic [8:0] wt[9] = '{9'h001, 9'h008, 9'h188, 9'h082, 9'h148, 9'h042, 9'h044, 9'h050, 9'h060};
  logic [5:0] mw[3] = '{6'h20, 6'h10, 6'h04};
  pbws_partner u_ptn (.clk(clk), .button(btn), .wake(wake));
  pbws_top #(.SHORT_CYC(40), .FORCE_CYC(60), .GUARD_CYC(20)) DUT (.CORE_CLK(clk), .SRST(srst),
    .PWR_BUTTON(btn), .WAKE_IN(wake), .CFG(cfg), .AC_RESTORED(ac), .OS_SLEEP_REQ(osr),
    .SYS_STATE(st), .MAIN_PWR_EN(pwr), .CTX_RAM(cram), .CTX_DISK(cdisk), .COLD_BOOT(cboot),
    .SLEEP_REQ(sreq), .MONITOR_SLEEP(mon), .WAKE_LOGIC_ON(wlon));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xorshift();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Each state lights exactly one of rails, memory, disk and cold boot, in that order.
  function automatic logic [3:0] ctx_of(input logic [2:0] s);
    return 4'h8 >> s;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(input logic [3:0] seen, input logic [3:0] want);
    samples_checked++;
    if (seen !== want) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic note(input logic s, input pbws_state_t e);
    exp_q.push_back({s, e});
  endtask
  task automatic strobe(input logic a);
    ac = a;
    osr = !a;
    tick(1);
    ac = 1'b0;
    osr = 1'b0;
  endtask
  task automatic short_press();
    u_ptn.press(1 + int'(xorshift() % 30));
  endtask
  task automatic done_test(input string nm);
    tick(6);
    check(4'(exp_q.size()), 4'h0);
    $display("test %s ended", nm);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Any state change or sleep request is an event; one with no note fails.
  always @(posedge clk) begin
    #2;
    if (!srst && (sreq === 1'b1 || st !== last_st)) begin
      want = exp_q.size() > 0 ? exp_q.pop_front() : 4'hF;
      check({sreq, st}, want);
      check({pwr, cram, cdisk, cboot}, ctx_of(want[2:0]));
      check({3'h0, wlon}, 4'h1);
    end
    last_st = st;
  end
  // The whole run needs under 2000 cycles, so this margin only trips on a hang.
  initial begin
    repeat (8000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    srst = 1'b1;
    ac = 1'b0;
    osr = 1'b0;
    cfg = '0;
    tick(12);
    srst = 1'b0;
    note(1'b0, PBWS_S0);
    short_press();
    done_test("power on");
    for (int k = 0; k < 3; k++) begin
      cfg.sleep_to_s4 = (k == 1);
      cfg.sleep_to_off = (k == 2);
      note(1'b1, PBWS_S0);
      short_press();
      tick(6);
      note(1'b0, pbws_state_t'(k + 1));
      strobe(1'b0);
      tick(4);
      note(1'b0, PBWS_S0);
      short_press();
      tick(2);
      check({3'h0, mon}, 4'h0);
      done_test("sleep and wake");
    end
    cfg.sleep_to_off = 1'b0;
    u_ptn.press(50);
    done_test("middle hold");
    note(1'b1, PBWS_S0);
    short_press();
    tick(6);
    note(1'b0, PBWS_S3);
    strobe(1'b0);
    tick(4);
    note(1'b0, PBWS_S0);
    u_ptn.wake_for(mw[xorshift() % 3], 3);
    check({3'h0, mon}, 4'h1);
    done_test("monitor asleep");
    note(1'b0, PBWS_S5);
    u_ptn.press(70);
    done_test("forced off");
    for (int i = 0; i < 9; i++) begin
      cfg.usb_s45_en = wt[i][8];
      cfg.deep_sleep = wt[i][7];
      if (wt[i][6])
        note(1'b0, PBWS_S0);
      u_ptn.wake_for(wt[i][5:0], 3);
      tick(4);
      if (wt[i][6]) begin
        check({3'h0, mon}, 4'h0);
        note(1'b0, PBWS_S5);
        u_ptn.press(70);
      end
      done_test("wake gating");
    end
    cfg.usb_s45_en = 1'b1;
    cfg.deep_sleep = 1'b0;
    strobe(1'b1);
    u_ptn.wake_for(6'h08, 3);
    u_ptn.wake_for(6'h02, 3);
    done_test("mains guard");
    cfg.deep_sleep = 1'b1;
    u_ptn.wake_for(6'h10, 3);
    tick(4);
    cfg.deep_sleep = 1'b0;
    note(1'b0, PBWS_S0);
    u_ptn.wake_for(6'h10, 3);
    done_test("network after loss");
    cfg.last_state_policy = LPS_ON;
    note(1'b0, PBWS_S5);
    u_ptn.press(70);
    tick(4);
    note(1'b0, PBWS_S0);
    strobe(1'b1);
    done_test("policy on");
    cfg.last_state_policy = LPS_LAST;
    strobe(1'b1);
    note(1'b0, PBWS_S5);
    u_ptn.press(70);
    tick(4);
    strobe(1'b1);
    done_test("policy last");
    tally_and_finish();
  end
endmodule
`default_nettype wire
